// ==== verilog/csle_pkg.sv ====
// Purpose: shared constants and types for the channel status LED encoder
// Assumes: 100 MHz clk, 32-bit register port with byte addresses
// Notes: all offsets, field positions, resets and timing counts live here
package csle_pkg;
  // channel count and register port widths
  localparam int NCH = 8;
  localparam int AW = 8;
  localparam int DW = 32;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHCFG = 8'h04;
  localparam logic [7:0] ADDR_LIVE = 8'h08;
  localparam logic [7:0] ADDR_HELD = 8'h0C;
  localparam logic [7:0] ADDR_PAT = 8'h10;
  localparam logic [7:0] ADDR_IRQST = 8'h14;
  localparam logic [7:0] ADDR_IRQMSK = 8'h18;
  // control register bits
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_ARST_BIT = 1;
  localparam int CTRL_SINGLE_BIT = 2;
  // byte lanes of the per-channel groups
  localparam int GRP0_LSB = 0;
  localparam int GRP1_LSB = 8;
  localparam int GRP2_LSB = 16;
  localparam int GRP3_LSB = 24;
  localparam int PAT_W = 3;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] GRP_RST = 8'h00;
  // timing: 1 ms tick, blink half periods in ms
  localparam longint CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = int'((CLK_HZ / 1_000_000) * TICK_US);
  localparam int FAST_HALF_MS = 125;
  localparam int SLOW_HALF_MS = 500;
  // indicator patterns, listed from highest to lowest priority
  typedef enum logic [2:0] {
    PAT_OFF, PAT_BLINK, PAT_SLOW, PAT_RED, PAT_YELLOW, PAT_GREEN
  } csle_pat_t;
endpackage : csle_pkg

// ==== verilog/csle_blink_gen.sv ====
// Purpose: blink phase generator shared by all channels
// Assumes: one clock, 1 ms enable pulse from a divider
// Notes: phases are common so all blinking channels stay in step
`timescale 1ns/1ps
module csle_blink_gen import csle_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC // cycles per 1 ms tick
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  output logic fastPhase, // fast blink phase
  output logic slowPhase // slow blink phase, about 1 Hz
);
  logic [31:0] tickCnt_r; // divider for the ms tick
  logic tickEn; // one-cycle ms enable
  logic [15:0] fastCnt_r; // ms within fast half period
  logic [15:0] slowCnt_r; // ms within slow half period

  assign tickEn = (tickCnt_r == 32'(TICK_CYCLES - 1));

  // ms divider
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tickCnt_r <= 32'h0;
    else if (tickEn) tickCnt_r <= 32'h0;
    else tickCnt_r <= tickCnt_r + 32'h1;
  end

  // fast phase toggles every fast half period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fastCnt_r <= 16'h0;
      fastPhase <= 1'b0;
    end else if (tickEn) begin
      if (fastCnt_r == 16'(FAST_HALF_MS - 1)) begin
        fastCnt_r <= 16'h0;
        fastPhase <= ~fastPhase;
      end else fastCnt_r <= fastCnt_r + 16'h1;
    end
  end

  // slow phase toggles every slow half period
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slowCnt_r <= 16'h0;
      slowPhase <= 1'b0;
    end else if (tickEn) begin
      if (slowCnt_r == 16'(SLOW_HALF_MS - 1)) begin
        slowCnt_r <= 16'h0;
        slowPhase <= ~slowPhase;
      end else slowCnt_r <= slowCnt_r + 16'h1;
    end
  end
endmodule : csle_blink_gen

// ==== verilog/csle_chan_enc.sv ====
// Purpose: one channel's alarm latches and priority pattern encoder
// Assumes: condition inputs synchronous to clk
// Notes: outputs registered, one cycle after the conditions
`timescale 1ns/1ps
module csle_chan_enc import csle_pkg::*; (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic run, // card configuration running
  input wire logic singleMode, // single-channel processing
  input wire logic configured, // channel configured
  input wire logic invalid, // input outside validity limits
  input wire logic inhibit, // channel inhibit active
  input wire logic dangerLive, // danger crossing present
  input wire logic alertLive, // alert crossing present
  input wire logic dangerLatMode, // danger alarm latched mode
  input wire logic alertLatMode, // alert alarm latched mode
  input wire logic alarmReset, // one-cycle latch clear
  input wire logic fastPhase, // fast blink phase
  input wire logic slowPhase, // slow blink phase
  output logic dangerHeld, // danger latch state
  output logic alertHeld, // alert latch state
  output csle_pat_t pattern, // selected pattern
  output logic red, // red LED drive
  output logic green // green LED drive
);
  csle_pat_t patNxt; // combinational pattern choice
  logic dangerShow; // danger live or held
  logic alertShow; // alert live or held
  logic dangerPrev_r; // danger live last cycle
  logic alertPrev_r; // alert live last cycle

  // previous live samples, so only a fresh crossing latches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dangerPrev_r <= 1'b0;
      alertPrev_r <= 1'b0;
    end else begin
      dangerPrev_r <= dangerLive;
      alertPrev_r <= alertLive;
    end
  end

  // [R11] latch per level, set by a new crossing
  // [R12] reset clears; a crossing still present shows live only
  // a fresh onset in the reset cycle still wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) dangerHeld <= 1'b0;
    else if (dangerLive && !dangerPrev_r && dangerLatMode) dangerHeld <= 1'b1;
    else if (alarmReset || !dangerLatMode) dangerHeld <= 1'b0;
  end

  // [R11] alert latch, same policy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) alertHeld <= 1'b0;
    else if (alertLive && !alertPrev_r && alertLatMode) alertHeld <= 1'b1;
    else if (alarmReset || !alertLatMode) alertHeld <= 1'b0;
  end

  // [R7] [R9] held or live crossing shows
  assign dangerShow = dangerLive | dangerHeld;
  assign alertShow = alertLive | alertHeld;

  // [R2] fixed priority encoder
  always_comb begin
    // [R3] off beats all
    if (!configured || !run) patNxt = PAT_OFF;
    // [R4] invalid input blinks
    else if (invalid) patNxt = PAT_BLINK;
    // [R5] inhibit slow blink
    else if (singleMode && inhibit) patNxt = PAT_SLOW;
    // [R6] danger red in single mode
    else if (singleMode && dangerShow) patNxt = PAT_RED;
    // [R8] alert yellow; multi-mode danger also blocks green
    else if (alertShow || dangerShow) patNxt = PAT_YELLOW;
    // [R10] green only when clean
    else patNxt = PAT_GREEN;
  end

  // registered pattern and LED drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern <= PAT_OFF;
      red <= 1'b0;
      green <= 1'b0;
    end else begin
      pattern <= patNxt;
      unique case (patNxt)
        PAT_OFF: begin red <= 1'b0; green <= 1'b0; end
        PAT_BLINK: begin red <= 1'b0; green <= fastPhase; end
        PAT_SLOW: begin red <= 1'b0; green <= slowPhase; end
        PAT_RED: begin red <= 1'b1; green <= 1'b0; end
        PAT_YELLOW: begin red <= 1'b1; green <= 1'b1; end
        PAT_GREEN: begin red <= 1'b0; green <= 1'b1; end
      endcase
    end
  end
endmodule : csle_chan_enc

// ==== verilog/csle_top.sv ====
// Purpose: eight-channel status LED encoder with register port and irq
// Assumes: single 100 MHz clock, inputs synchronous, async low reset
// Notes: yellow is shown as red and green lit together
//
// Overview of operation
// [R1] one independent indicator per channel
// [R2] priority: off, blink, slow, red, yellow, green
// [R3] off if unconfigured or not running
// [R4] fast green blink on invalid input
// [R5] slow green blink on inhibit, single mode
// [R6] live danger lights red, single mode
// [R7] latched danger red until reset, single mode
// [R8] live alert lights yellow
// [R9] latched alert yellow until reset
// [R10] green only when configured, valid, alarm free
// [R11] each level selectable latched or not
// [R12] reset pulse clears all alarm latches; a latch whose fresh onset falls in the reset cycle is set instead
`timescale 1ns/1ps
module csle_top import csle_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC // cycles per 1 ms tick
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [AW-1:0] addr, // register byte address
  input wire logic [DW-1:0] wrData, // register write data
  input wire logic wrEn, // write strobe, one cycle
  input wire logic rdEn, // read strobe, one cycle
  output logic [DW-1:0] rdData, // read data, cycle after rdEn
  input wire logic [NCH-1:0] chInvalid, // input beyond validity limits
  input wire logic [NCH-1:0] chInhibit, // inhibit function active
  input wire logic [NCH-1:0] chDanger, // danger crossing present
  input wire logic [NCH-1:0] chAlert, // alert crossing present
  input wire logic alarmResetIn, // external alarm reset pulse
  output logic [NCH-1:0] ledRed, // red element per channel
  output logic [NCH-1:0] ledGreen, // green element per channel
  output logic irq // level interrupt, active high
);

  // control state written by software
  logic runCfg_r; // card configuration running
  logic singleCfg_r; // single-channel processing mode
  logic [NCH-1:0] confCfg_r; // channel configured
  logic [NCH-1:0] dLatCfg_r; // danger latched mode
  logic [NCH-1:0] aLatCfg_r; // alert latched mode

  // interrupt state
  logic [NCH-1:0] stDanger_r; // sticky danger onset
  logic [NCH-1:0] stAlert_r; // sticky alert onset
  logic [NCH-1:0] stInvalid_r; // sticky invalid onset
  logic [NCH-1:0] mskDanger_r; // danger enable mask
  logic [NCH-1:0] mskAlert_r; // alert enable mask
  logic [NCH-1:0] mskInvalid_r; // invalid enable mask

  // previous values for onset detection
  logic [NCH-1:0] prevDanger_r; // danger last cycle
  logic [NCH-1:0] prevAlert_r; // alert last cycle
  logic [NCH-1:0] prevInvalid_r; // invalid last cycle

  // decoded strobes
  logic wrCtrl; // write to control
  logic wrChcfg; // write to channel config
  logic wrIrqSt; // write-one-clear to status
  logic wrIrqMsk; // write to mask
  logic alarmReset; // merged one-cycle latch clear

  // event pulses
  logic [NCH-1:0] evDanger; // danger rising edge
  logic [NCH-1:0] evAlert; // alert rising edge
  logic [NCH-1:0] evInvalid; // invalid rising edge

  // per-channel results from the encoders
  logic [NCH-1:0] dangerHeld; // danger latches
  logic [NCH-1:0] alertHeld; // alert latches
  csle_pat_t chPat [NCH]; // pattern per channel
  logic [NCH*PAT_W-1:0] patFlat; // patterns packed for readback

  // blink phases shared by all channels
  logic fastPhase; // fast blink phase
  logic slowPhase; // slow blink phase

  // read path
  logic [DW-1:0] rdNxt; // read data chosen this cycle

  // address decode; writes never stall
  assign wrCtrl = wrEn && (addr == ADDR_CTRL);
  assign wrChcfg = wrEn && (addr == ADDR_CHCFG);
  assign wrIrqSt = wrEn && (addr == ADDR_IRQST);
  assign wrIrqMsk = wrEn && (addr == ADDR_IRQMSK);

  // [R12] alarm reset from software bit or the pin
  // the control bit is self-clearing, so it is a pulse, never a level
  assign alarmReset = alarmResetIn || (wrCtrl && wrData[CTRL_ARST_BIT]);

  // control register: run and processing mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runCfg_r <= CTRL_RST[CTRL_RUN_BIT];
      singleCfg_r <= CTRL_RST[CTRL_SINGLE_BIT];
    end else if (wrCtrl) begin
      runCfg_r <= wrData[CTRL_RUN_BIT];
      singleCfg_r <= wrData[CTRL_SINGLE_BIT];
    end
  end

  // channel configuration register
  // [R11] latched mode chosen per level, per channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      confCfg_r <= GRP_RST;
      dLatCfg_r <= GRP_RST;
      aLatCfg_r <= GRP_RST;
    end else if (wrChcfg) begin
      confCfg_r <= wrData[GRP0_LSB +: NCH];
      dLatCfg_r <= wrData[GRP1_LSB +: NCH];
      aLatCfg_r <= wrData[GRP2_LSB +: NCH];
    end
  end

  // mask register, same layout as status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mskDanger_r <= GRP_RST;
      mskAlert_r <= GRP_RST;
      mskInvalid_r <= GRP_RST;
    end else if (wrIrqMsk) begin
      mskDanger_r <= wrData[GRP0_LSB +: NCH];
      mskAlert_r <= wrData[GRP1_LSB +: NCH];
      mskInvalid_r <= wrData[GRP2_LSB +: NCH];
    end
  end

  // previous samples for onset edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevDanger_r <= GRP_RST;
      prevAlert_r <= GRP_RST;
      prevInvalid_r <= GRP_RST;
    end else begin
      prevDanger_r <= chDanger;
      prevAlert_r <= chAlert;
      prevInvalid_r <= chInvalid;
    end
  end

  // onset pulses; only configured channels raise events,
  // otherwise an idle channel with floating inputs would spam irq
  assign evDanger = chDanger & ~prevDanger_r & confCfg_r;
  assign evAlert = chAlert & ~prevAlert_r & confCfg_r;
  assign evInvalid = chInvalid & ~prevInvalid_r & confCfg_r;

  // sticky status, write one to clear; a new event wins the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stDanger_r <= GRP_RST;
      stAlert_r <= GRP_RST;
      stInvalid_r <= GRP_RST;
    end else begin
      stDanger_r <= evDanger |
        (stDanger_r & ~({NCH{wrIrqSt}} & wrData[GRP0_LSB +: NCH]));
      stAlert_r <= evAlert |
        (stAlert_r & ~({NCH{wrIrqSt}} & wrData[GRP1_LSB +: NCH]));
      stInvalid_r <= evInvalid |
        (stInvalid_r & ~({NCH{wrIrqSt}} & wrData[GRP2_LSB +: NCH]));
    end
  end

  // interrupt line, registered so it is glitch free at the pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) irq <= 1'b0;
    else irq <= |{stDanger_r & mskDanger_r,
                  stAlert_r & mskAlert_r,
                  stInvalid_r & mskInvalid_r};
  end

  // shared blink phase generator
  csle_blink_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_blink (
    .clk(clk),
    .reset_n(reset_n),
    .fastPhase(fastPhase),
    .slowPhase(slowPhase)
  );

  // [R1] one encoder per channel, fed only its own conditions
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    csle_chan_enc u_enc (
      .clk(clk),
      .reset_n(reset_n),
      .run(runCfg_r),
      .singleMode(singleCfg_r),
      .configured(confCfg_r[ch]),
      .invalid(chInvalid[ch]),
      .inhibit(chInhibit[ch]),
      .dangerLive(chDanger[ch]),
      .alertLive(chAlert[ch]),
      .dangerLatMode(dLatCfg_r[ch]),
      .alertLatMode(aLatCfg_r[ch]),
      .alarmReset(alarmReset),
      .fastPhase(fastPhase),
      .slowPhase(slowPhase),
      .dangerHeld(dangerHeld[ch]),
      .alertHeld(alertHeld[ch]),
      .pattern(chPat[ch]),
      .red(ledRed[ch]),
      .green(ledGreen[ch])
    );
    // pack pattern codes, channel 0 in the low bits
    assign patFlat[ch*PAT_W +: PAT_W] = chPat[ch];
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdNxt = 32'h0;
    unique case (addr)
      ADDR_CTRL: begin
        // alarm reset bit always reads zero
        rdNxt[CTRL_RUN_BIT] = runCfg_r;
        rdNxt[CTRL_SINGLE_BIT] = singleCfg_r;
      end
      ADDR_CHCFG: begin
        rdNxt[GRP0_LSB +: NCH] = confCfg_r;
        rdNxt[GRP1_LSB +: NCH] = dLatCfg_r;
        rdNxt[GRP2_LSB +: NCH] = aLatCfg_r;
      end
      ADDR_LIVE: begin
        // raw condition inputs as seen now
        rdNxt[GRP0_LSB +: NCH] = chInvalid;
        rdNxt[GRP1_LSB +: NCH] = chDanger;
        rdNxt[GRP2_LSB +: NCH] = chAlert;
        rdNxt[GRP3_LSB +: NCH] = chInhibit;
      end
      ADDR_HELD: begin
        rdNxt[GRP0_LSB +: NCH] = dangerHeld;
        rdNxt[GRP1_LSB +: NCH] = alertHeld;
      end
      ADDR_PAT: begin
        rdNxt[NCH*PAT_W-1:0] = patFlat;
      end
      ADDR_IRQST: begin
        rdNxt[GRP0_LSB +: NCH] = stDanger_r;
        rdNxt[GRP1_LSB +: NCH] = stAlert_r;
        rdNxt[GRP2_LSB +: NCH] = stInvalid_r;
      end
      ADDR_IRQMSK: begin
        rdNxt[GRP0_LSB +: NCH] = mskDanger_r;
        rdNxt[GRP1_LSB +: NCH] = mskAlert_r;
        rdNxt[GRP2_LSB +: NCH] = mskInvalid_r;
      end
      default: begin
        // any other address answers zero
        rdNxt = 32'h0;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  // status reads have no side effect; clearing is by write only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rdData <= 32'h0;
    else if (rdEn) rdData <= rdNxt;
    else rdData <= 32'h0;
  end

endmodule : csle_top

// ==== dv/csle_led_panel.sv ====
// Purpose: front panel model, one bicolour lamp per channel
// Assumes: high drive lights an element, both lit reads as yellow
// Notes: colour per channel, 0 dark, 1 green, 2 red, 3 yellow
`timescale 1ns/1ps
module csle_led_panel import csle_pkg::*; (
  input wire logic [NCH-1:0] ledRed, // red elements
  input wire logic [NCH-1:0] ledGreen, // green elements
  output logic [2*NCH-1:0] colour // seen colour per channel
);
  // a bicolour lamp mixes both elements, so no state is kept
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      colour[2*i +: 2] = {ledRed[i], ledGreen[i]};
    end
  end
endmodule : csle_led_panel

// ==== dv/csle_top_sva.sv ====
// Purpose: port checks for the channel status LED encoder
// Assumes: configuration mirrored from register writes
// Notes: blink timing is judged by the bench, not here
`timescale 1ns/1ps
module csle_top_sva import csle_pkg::*; (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [AW-1:0] addr, // register address
  input wire logic [DW-1:0] wrData, // write data
  input wire logic wrEn, // write strobe
  input wire logic rdEn, // read strobe
  input wire logic [DW-1:0] rdData, // read data
  input wire logic [NCH-1:0] chInvalid, // invalid inputs
  input wire logic [NCH-1:0] chInhibit, // inhibit inputs
  input wire logic [NCH-1:0] chDanger, // danger inputs
  input wire logic [NCH-1:0] chAlert, // alert inputs
  input wire logic alarmResetIn, // latch reset pin
  input wire logic [NCH-1:0] ledRed, // red elements
  input wire logic [NCH-1:0] ledGreen, // green elements
  input wire logic irq // interrupt
);
  logic run_r; // mirrored run bit
  logic single_r; // mirrored single mode
  logic [7:0] cfg_r; // mirrored configured bits
  logic [7:0] dLat_r; // mirrored danger latch mode
  logic [7:0] aLat_r; // mirrored alert latch mode
  logic [23:0] msk_r; // mirrored irq mask
  logic [NCH-1:0] act; // running, configured and valid
  assign act = {NCH{run_r}} & cfg_r & ~chInvalid;
  // mirror updates at the same edge as the design registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_r <= 1'b0;
      single_r <= 1'b0;
      cfg_r <= 8'h00;
      dLat_r <= 8'h00;
      aLat_r <= 8'h00;
      msk_r <= 24'h000000;
    end else if (wrEn && addr == ADDR_CTRL) begin
      run_r <= wrData[CTRL_RUN_BIT];
      single_r <= wrData[CTRL_SINGLE_BIT];
    end else if (wrEn && addr == ADDR_CHCFG) begin
      cfg_r <= wrData[7:0];
      dLat_r <= wrData[15:8];
      aLat_r <= wrData[23:16];
    end else if (wrEn && addr == ADDR_IRQMSK) begin
      msk_r <= wrData[23:0];
    end
  end
  // holes in the map and odd addresses must read as zero
  a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
    rdEn && (addr > ADDR_IRQMSK || addr[1:0] != 2'h0) |=> rdData == '0)
    else $error("unmapped read not zero");
  // a fully masked status never raises the interrupt
  a_irq_masked: assert property (@(posedge clk) disable iff (!reset_n)
    msk_r == '0 && $past(msk_r) == '0 |-> !irq) else $error("irq while masked");
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    a_chan_off: assert property (@(posedge clk) disable iff (!reset_n)
      !(run_r && cfg_r[i]) |=> !ledRed[i] && !ledGreen[i]) else $error("led not off");
    a_invalid_blink: assert property (@(posedge clk) disable iff (!reset_n)
      run_r && cfg_r[i] && chInvalid[i] |=> !ledRed[i]) else $error("red on invalid");
    a_inhibit_slow: assert property (@(posedge clk) disable iff (!reset_n)
      act[i] && single_r && chInhibit[i] |=> !ledRed[i]) else $error("red on inhibit");
    a_danger_red: assert property (@(posedge clk) disable iff (!reset_n)
      act[i] && single_r && !chInhibit[i] && chDanger[i] |=> ledRed[i] && !ledGreen[i])
      else $error("danger not red");
    a_latch_red: assert property (@(posedge clk) disable iff (!reset_n)
      act[i] && single_r && !chInhibit[i] && chDanger[i] && !$past(chDanger[i]) &&
      dLat_r[i] ##1
      act[i] && single_r && !chInhibit[i] && dLat_r[i] && !alarmResetIn && !wrEn
      |=> ledRed[i] && !ledGreen[i]) else $error("latched danger lost");
    a_alert_yellow: assert property (@(posedge clk) disable iff (!reset_n)
      act[i] && !single_r && chAlert[i] |=> ledRed[i] && ledGreen[i])
      else $error("alert not yellow");
    a_latch_yellow: assert property (@(posedge clk) disable iff (!reset_n)
      act[i] && chAlert[i] && !$past(chAlert[i]) && aLat_r[i] && !dLat_r[i] ##1
      act[i] && aLat_r[i] && !dLat_r[i] && !chDanger[i] && !(single_r && chInhibit[i]) &&
      !alarmResetIn && !wrEn |=> ledRed[i] && ledGreen[i]) else $error("latched alert lost");
    a_green_clear: assert property (@(posedge clk) disable iff (!reset_n)
      act[i] && !chDanger[i] && !chAlert[i] && !(single_r && chInhibit[i]) &&
      !dLat_r[i] && !aLat_r[i] && !$past(dLat_r[i]) && !$past(aLat_r[i])
      |=> !ledRed[i] && ledGreen[i]) else $error("clear channel not green");
  end
endmodule : csle_top_sva

bind csle_top csle_top_sva chk_i (.clk(clk), .reset_n(reset_n), .addr(addr),
  .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .chInvalid(chInvalid),
  .chInhibit(chInhibit), .chDanger(chDanger), .chAlert(chAlert),
  .alarmResetIn(alarmResetIn), .ledRed(ledRed), .ledGreen(ledGreen), .irq(irq));

// ==== dv/test_channel_status_led_encoder.sv ====
// Purpose: self-checking bench for the channel status LED encoder
// Assumes: short tick of 4 cycles, so a fast half blink is 500 cycles
// Notes: reads are checked by a watcher against a queue of notes
`timescale 1ns/1ps
module test_channel_status_led_encoder import csle_pkg::*;;
  localparam int TK = 4; // short tick keeps blink periods small
  logic clk, reset_n, wrEn, rdEn, alarmResetIn, irq;
  logic rdPend = 1'b0; // a read answer is due this edge
  logic [AW-1:0] addr;
  logic [DW-1:0] wrData, rdData;
  logic [NCH-1:0] chInvalid, chInhibit, chDanger, chAlert, ledRed, ledGreen;
  logic [2*NCH-1:0] colour; // lamp colours seen on the panel
  logic [DW-1:0] expQ[$]; // expected read data, oldest first
  int miscompares = 0, nChecks = 0, cyc = 0;
  csle_top #(.TICK_CYCLES(TK)) DUT (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .chInvalid(chInvalid),
    .chInhibit(chInhibit), .chDanger(chDanger), .chAlert(chAlert),
    .alarmResetIn(alarmResetIn), .ledRed(ledRed), .ledGreen(ledGreen), .irq(irq));
  csle_led_panel panel (.ledRed(ledRed), .ledGreen(ledGreen), .colour(colour));
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] want);
    nChecks++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // strobes drop for one cycle between accesses, so no double drive
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(posedge clk);
  endtask : rd
  // expected pattern from the priority order, latches left out
  function automatic logic [2:0] patOf(input logic run, sgl, cfg, inv, inh, dng, alt);
    if (!run || !cfg) return PAT_OFF;
    if (inv) return PAT_BLINK;
    if (sgl && inh) return PAT_SLOW;
    if (sgl && dng) return PAT_RED;
    if (alt || dng) return PAT_YELLOW;
    return PAT_GREEN;
  endfunction : patOf
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watcher: answer stands only in the cycle after the strobe
  always @(posedge clk) begin
    rdPend <= rdEn;
    if (rdPend) begin
      chk(rdData, expQ.pop_front());
    end
  end
  // hang guard, a full run needs about 2500 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  initial begin
    logic run, sgl;
    logic [7:0] cfg;
    logic [2:0] p;
    logic [31:0] exp;
    int fast, slow, seed;
    {wrEn, rdEn, alarmResetIn, addr, wrData} = '0;
    {chInvalid, chInhibit, chDanger, chAlert} = '0;
    reset_n = 1'b0;
    seed = $urandom(9301);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(DW'(colour), '0);
    wr(8'h1C, 32'hFFFFFFFF);
    wr(ADDR_LIVE, 32'hFFFFFFFF);
    for (int a = 0; a < 32; a += 4) rd(8'(a), '0);
    rd(8'h02, '0);
    $display("done: reset values");
    for (int k = 0; k < 24; k++) begin
      run = (k % 6) != 5;
      sgl = 1'($urandom);
      cfg = 8'($urandom);
      wr(ADDR_CTRL, {29'h0, sgl, 1'b0, run});
      wr(ADDR_CHCFG, {24'h0, cfg});
      chInvalid <= 8'($urandom & $urandom & $urandom);
      chInhibit <= 8'($urandom & $urandom);
      chDanger <= 8'($urandom & $urandom);
      chAlert <= 8'($urandom);
      repeat (3) @(posedge clk);
      exp = '0;
      for (int i = 0; i < NCH; i++) begin
        p = patOf(run, sgl, cfg[i], chInvalid[i], chInhibit[i], chDanger[i], chAlert[i]);
        exp[3*i +: 3] = p;
        if (p == PAT_BLINK || p == PAT_SLOW) begin
          chk(DW'(colour[2*i+1]), '0);
        end else begin
          chk(DW'(colour[2*i +: 2]), p == PAT_OFF ? 0 : p == PAT_RED ? 2 : p == PAT_YELLOW ? 3 : 1);
        end
      end
      rd(ADDR_PAT, exp);
      rd(ADDR_LIVE, {chInhibit, chAlert, chDanger, chInvalid});
      rd(ADDR_CTRL, {29'h0, sgl, 1'b0, run});
    end
    $display("done: random priority");
    {chInvalid, chInhibit, chDanger, chAlert} <= '0;
    wr(ADDR_CTRL, 32'h00000005);
    wr(ADDR_CHCFG, 32'h000201FF);
    chDanger <= 8'h05;
    chAlert <= 8'h02;
    @(posedge clk);
    {chDanger, chAlert} <= '0;
    repeat (3) @(posedge clk);
    rd(ADDR_HELD, 32'h00000201);
    rd(ADDR_PAT, 32'h00B6DB63);
    chk(DW'(colour[5:0]), 32'h1E);
    wr(ADDR_CTRL, 32'h00000007);
    rd(ADDR_HELD, '0);
    rd(ADDR_PAT, 32'h00B6DB6D);
    chDanger <= 8'h01;
    @(posedge clk);
    chDanger <= 8'h00;
    repeat (2) @(posedge clk);
    alarmResetIn <= 1'b1;
    @(posedge clk);
    alarmResetIn <= 1'b0;
    rd(ADDR_HELD, '0);
    chDanger <= 8'h01;
    @(posedge clk);
    alarmResetIn <= 1'b1;
    @(posedge clk);
    alarmResetIn <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ADDR_HELD, '0);
    chk(DW'(colour[1:0]), 2);
    chDanger <= 8'h00;
    $display("done: latches");
    wr(ADDR_IRQST, 32'hFFFFFFFF);
    wr(ADDR_IRQMSK, 32'h00000001);
    chk(DW'(irq), '0);
    chDanger <= 8'h01;
    chAlert <= 8'h08;
    repeat (4) @(posedge clk);
    chk(DW'(irq), 1);
    rd(ADDR_IRQST, 32'h00000801);
    wr(ADDR_IRQST, 32'h00000001);
    @(posedge clk);
    chk(DW'(irq), '0);
    wr(ADDR_IRQMSK, 32'h00000800);
    @(posedge clk);
    chk(DW'(irq), 1);
    wr(ADDR_IRQST, 32'h00000800);
    @(posedge clk);
    chk(DW'(irq), '0);
    {chDanger, chAlert} <= '0;
    $display("done: interrupt");
    chInvalid <= 8'h01;
    chInhibit <= 8'h02;
    fast = 0;
    slow = 0;
    repeat (3) @(posedge clk);
    for (int c = 0; c < 2100; c++) begin
      p[1:0] = ledGreen[1:0];
      @(posedge clk);
      #1;
      fast += int'(ledGreen[0] != p[0]);
      slow += int'(ledGreen[1] != p[1]);
    end
    @(posedge clk);
    chk(DW'(fast >= 4 && fast <= 5 && slow >= 1 && slow <= 2), 1);
    $display("done: blink rates");
    rd(ADDR_IRQST, 32'h00010000);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : test_channel_status_led_encoder
